// [atc_pkg.sv]
// Constants, register map and carrier types for the 8-bit timer/counter.
// Assumes a single 125 MHz system clock and a plain strobe register port.
package atc_pkg;

	// ****************************************
	// Register map (byte offsets on the port)
	// ****************************************
	localparam logic [2:0] ATC_ADDR_COUNTER = 3'h0;
	localparam logic [2:0] ATC_ADDR_COMPARE = 3'h1;
	localparam logic [2:0] ATC_ADDR_CTRL_A  = 3'h2;
	localparam logic [2:0] ATC_ADDR_CTRL_B  = 3'h3;
	localparam logic [2:0] ATC_ADDR_FLAGS   = 3'h4;
	localparam logic [2:0] ATC_ADDR_MASK    = 3'h5;
	localparam logic [2:0] ATC_ADDR_ASYNC   = 3'h6;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ATC_BIT_OVERFLOW = 0;
	localparam int ATC_BIT_COMPARE  = 1;
	localparam int ATC_BIT_DIR_DOWN = 3;
	localparam int ATC_BIT_ASYNC    = 0;

	// ****************************************
	// Values
	// ****************************************
	localparam logic [7:0] ATC_BOTTOM    = 8'h00;
	localparam logic [7:0] ATC_MAX       = 8'hFF;
	localparam logic [7:0] ATC_RST_BYTE  = 8'h00;
	localparam logic [2:0] ATC_CS_STOP   = 3'h0;
	localparam logic [9:0] ATC_PRE_RST   = 10'h000;
	localparam int         ATC_PRE_WIDTH = 10;

	typedef enum logic [1:0] {
		ATC_WGM_NORMAL = 2'b00,
		ATC_WGM_PHASE  = 2'b01,
		ATC_WGM_CTC    = 2'b10,
		ATC_WGM_FAST   = 2'b11
	} atc_wgm_e;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} atc_req_s;

	// All state of the timer
	typedef struct packed {
		logic [7:0] counter_value;
		logic [7:0] compare_value;
		atc_wgm_e   waveform_mode_field;
		logic [2:0] clock_select_field;
		logic       async_clock_select;
		logic       dir_down;
		logic       overflow_flag;
		logic       compare_flag;
		logic       mask_overflow;
		logic       mask_compare;
		logic       block_match;
		logic [9:0] prescale;
		logic       xtal_s1;
		logic       xtal_s2;
		logic       xtal_s3;
		logic [7:0] rdata;
		logic       irq_overflow;
		logic       irq_compare;
		logic       at_bottom;
		logic       at_max;
	} atc_state_s;

endpackage : atc_pkg

// [atc_timer.sv]
// 8-bit timer/counter with one compare channel, overflow and compare flags.
// Assumes the crystal input is an unsynchronised pin and that software uses
// one-cycle strobes; read data stands in the cycle after the read strobe.
`timescale 1ns/10ps

// Functional notes
// - 8-bit counter and compare, compared always
// - Match sets compare flag, can interrupt
// - Flags visible, each individually masked
// - Clock select zero stops the counter
// - Async bit selects crystal over io clock
// - Flag bottom at 0x00, max at 0xFF
// - Top is 0xFF or compare, per mode
// - Each tick clears, increments or decrements
// - Counter readable and writable at any time
// - CPU counter write beats count or clear
// - Waveform mode bits set counting sequence
// - Overflow flag point depends on mode
// - Compare flag set one tick after match
// - Flag cleared by acknowledge or writing one
// - Counter write blocks next tick's match
// - Normal mode wraps, overflow on zero
module atc_timer
	import atc_pkg::*;
#(
	parameter int DIV1 = 1,
	parameter int DIV2 = 8,
	parameter int DIV3 = 32,
	parameter int DIV4 = 64,
	parameter int DIV5 = 128,
	parameter int DIV6 = 256,
	parameter int DIV7 = 1024
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Register port
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	// Crystal clock pin
	input  wire logic       crystal_in_pin_in,
	// Interrupt acknowledges from the CPU
	input  wire logic       ack_overflow_in,
	input  wire logic       ack_compare_in,
	// Interrupt requests and indications
	output logic            irq_overflow_out,
	output logic            irq_compare_out,
	output logic            at_bottom_out,
	output logic            at_max_out
);

	// ****************************************
	// Prescaler tap decode
	// ****************************************
	function automatic logic tap_hit(input logic [2:0] sel, input logic [9:0] pre);
		int div;
		div = 1;
		case (sel)
			3'h1: div = DIV1;
			3'h2: div = DIV2;
			3'h3: div = DIV3;
			3'h4: div = DIV4;
			3'h5: div = DIV5;
			3'h6: div = DIV6;
			3'h7: div = DIV7;
			default: div = 1;
		endcase
		tap_hit = ((pre & 10'(div - 1)) == 10'(div - 1));
	endfunction : tap_hit

	atc_req_s   req;
	atc_state_s st_q;
	atc_state_s st_d;
	logic       src_tick;
	logic       tick;
	logic       wr_counter;
	logic       match;
	logic [7:0] top_value;

	assign req.addr  = addr_in;
	assign req.wdata = wdata_in;
	assign req.wr    = wr_in;
	assign req.rd    = rd_in;

	// Crystal edge as seen after synchronisation; async mode counts crystal edges
	assign src_tick   = st_q.async_clock_select ? (st_q.xtal_s2 & ~st_q.xtal_s3) : 1'b1;
	assign tick       = (st_q.clock_select_field != ATC_CS_STOP) && src_tick
	                    && tap_hit(st_q.clock_select_field, st_q.prescale);
	assign wr_counter = req.wr && (req.addr == ATC_ADDR_COUNTER);
	assign match      = (st_q.counter_value == st_q.compare_value);
	assign top_value  = (st_q.waveform_mode_field == ATC_WGM_CTC) ? st_q.compare_value : ATC_MAX;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic set_ov;
		logic set_cm;
		logic [7:0] rd_val;
		set_ov = 1'b0;
		set_cm = 1'b0;
		rd_val = ATC_RST_BYTE;
		st_d = st_q;

		// Two-stage synchroniser, third stage only for edge detection
		st_d.xtal_s1 = crystal_in_pin_in;
		st_d.xtal_s2 = st_q.xtal_s1;
		st_d.xtal_s3 = st_q.xtal_s2;

		if (src_tick) begin
			st_d.prescale = st_q.prescale + 10'h001;
		end

		// ****************************************
		// Counter unit
		// ****************************************
		if (tick) begin
			// A match seen during the previous timer cycle raises the flag now
			set_cm = match && !st_q.block_match;
			st_d.block_match = 1'b0;
			case (st_q.waveform_mode_field)
				ATC_WGM_NORMAL, ATC_WGM_FAST: begin
					st_d.counter_value = st_q.counter_value + 8'h01;
					set_ov = (st_q.counter_value == ATC_MAX);
					st_d.dir_down = 1'b0;
				end
				ATC_WGM_CTC: begin
					if (st_q.counter_value == top_value) begin
						st_d.counter_value = ATC_BOTTOM;
					end else begin
						st_d.counter_value = st_q.counter_value + 8'h01;
					end
					set_ov = (st_q.counter_value == ATC_MAX);
					st_d.dir_down = 1'b0;
				end
				ATC_WGM_PHASE: begin
					if (st_q.dir_down) begin
						if (st_q.counter_value == ATC_BOTTOM) begin
							st_d.dir_down = 1'b0;
							st_d.counter_value = 8'h01;
							set_ov = 1'b1;
						end else begin
							st_d.counter_value = st_q.counter_value - 8'h01;
						end
					end else if (st_q.counter_value == ATC_MAX) begin
						st_d.dir_down = 1'b1;
						st_d.counter_value = ATC_MAX - 8'h01;
					end else begin
						st_d.counter_value = st_q.counter_value + 8'h01;
					end
				end
				default: begin
					st_d.counter_value = st_q.counter_value;
				end
			endcase
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (req.wr) begin
			case (req.addr)
				ATC_ADDR_COUNTER: begin
					st_d.counter_value = req.wdata;
					st_d.block_match = 1'b1;
				end
				ATC_ADDR_COMPARE: st_d.compare_value = req.wdata;
				ATC_ADDR_CTRL_A: begin
					st_d.waveform_mode_field = atc_wgm_e'(req.wdata[1:0]);
					st_d.dir_down = req.wdata[ATC_BIT_DIR_DOWN];
				end
				ATC_ADDR_CTRL_B: st_d.clock_select_field = req.wdata[2:0];
				ATC_ADDR_MASK: begin
					st_d.mask_overflow = req.wdata[ATC_BIT_OVERFLOW];
					st_d.mask_compare = req.wdata[ATC_BIT_COMPARE];
				end
				ATC_ADDR_ASYNC: st_d.async_clock_select = req.wdata[ATC_BIT_ASYNC];
				default: begin
					st_d.counter_value = st_d.counter_value;
				end
			endcase
		end

		// Flags: write-one or acknowledge clears, a same-cycle set wins
		if ((req.wr && req.addr == ATC_ADDR_FLAGS && req.wdata[ATC_BIT_OVERFLOW]) || ack_overflow_in) begin
			st_d.overflow_flag = 1'b0;
		end
		if ((req.wr && req.addr == ATC_ADDR_FLAGS && req.wdata[ATC_BIT_COMPARE]) || ack_compare_in) begin
			st_d.compare_flag = 1'b0;
		end
		if (set_ov) begin
			st_d.overflow_flag = 1'b1;
		end
		if (set_cm) begin
			st_d.compare_flag = 1'b1;
		end

		// ****************************************
		// Read data and outputs
		// ****************************************
		case (req.addr)
			ATC_ADDR_COUNTER: rd_val = st_q.counter_value;
			ATC_ADDR_COMPARE: rd_val = st_q.compare_value;
			ATC_ADDR_CTRL_A: rd_val = {4'h0, st_q.dir_down, 1'b0, st_q.waveform_mode_field};
			ATC_ADDR_CTRL_B: rd_val = {5'h00, st_q.clock_select_field};
			ATC_ADDR_FLAGS: rd_val = {6'h00, st_q.compare_flag, st_q.overflow_flag};
			ATC_ADDR_MASK: rd_val = {6'h00, st_q.mask_compare, st_q.mask_overflow};
			ATC_ADDR_ASYNC: rd_val = {7'h00, st_q.async_clock_select};
			default: rd_val = ATC_RST_BYTE;
		endcase
		st_d.rdata = req.rd ? rd_val : ATC_RST_BYTE;

		st_d.irq_overflow = st_d.overflow_flag && st_d.mask_overflow;
		st_d.irq_compare = st_d.compare_flag && st_d.mask_compare;
		st_d.at_bottom = (st_d.counter_value == ATC_BOTTOM);
		st_d.at_max = (st_d.counter_value == ATC_MAX);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= '{
				counter_value:       ATC_RST_BYTE,
				compare_value:       ATC_RST_BYTE,
				waveform_mode_field: ATC_WGM_NORMAL,
				clock_select_field:  ATC_CS_STOP,
				prescale:            ATC_PRE_RST,
				rdata:               ATC_RST_BYTE,
				at_bottom:           1'b1,
				default:             1'b0
			};
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_out        = st_q.rdata;
	assign irq_overflow_out = st_q.irq_overflow;
	assign irq_compare_out  = st_q.irq_compare;
	assign at_bottom_out    = st_q.at_bottom;
	assign at_max_out       = st_q.at_max;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	stop_holds_a: assert property (st_q.clock_select_field == ATC_CS_STOP && !wr_counter
		|=> $stable(st_q.counter_value)) else $error("counter moved while stopped");
	write_wins_a: assert property (wr_counter && tick
		|=> st_q.counter_value == $past(wdata_in)) else $error("counter write lost to count");
	read_counter_a: assert property (rd_in && addr_in == ATC_ADDR_COUNTER
		|=> rdata_out == $past(st_q.counter_value)) else $error("counter read wrong");
	match_flag_a: assert property (tick && match && !st_q.block_match
		|=> st_q.compare_flag) else $error("match did not set compare flag");
	block_match_a: assert property (wr_counter ##1 (tick && !st_q.compare_flag) ##0 (!ack_compare_in)
		|=> !st_q.compare_flag) else $error("match after counter write not blocked");
	normal_wrap_a: assert property (tick && !wr_counter && st_q.waveform_mode_field == ATC_WGM_NORMAL
		&& st_q.counter_value == ATC_MAX |=> st_q.counter_value == ATC_BOTTOM && st_q.overflow_flag)
		else $error("normal wrap or overflow wrong");
	count_up_a: assert property (tick && !wr_counter && st_q.waveform_mode_field == ATC_WGM_NORMAL
		|=> st_q.counter_value == 8'($past(st_q.counter_value) + 8'h01)) else $error("no increment");
	ctc_clear_a: assert property (tick && !wr_counter && st_q.waveform_mode_field == ATC_WGM_CTC && match
		|=> st_q.counter_value == ATC_BOTTOM) else $error("ctc did not clear at top");
	irq_mask_a: assert property (irq_compare_out |-> st_q.mask_compare && st_q.compare_flag)
		else $error("compare request not gated");
	bottom_ind_a: assert property (at_bottom_out == (st_q.counter_value == ATC_BOTTOM)
		&& at_max_out == (st_q.counter_value == ATC_MAX)) else $error("bottom or max wrong");
	w1c_clear_a: assert property (wr_in && addr_in == ATC_ADDR_FLAGS && wdata_in[ATC_BIT_COMPARE]
		&& !(tick && match) |=> !st_q.compare_flag) else $error("compare flag not cleared");

	ovf_irq_c: cover property (irq_overflow_out);
	cmp_irq_c: cover property (irq_compare_out);
	async_tick_c: cover property (st_q.async_clock_select && tick);
	phase_turn_c: cover property (tick && st_q.dir_down && st_q.counter_value == ATC_BOTTOM);

endmodule : atc_timer

// [atc_timer_tb_top.sv]
// Self-checking bench for the 8-bit timer/counter: register table, stop, wrap, compare, CTC, crystal source.
// Assumes the design's register map in atc_pkg and a prescaler tap of one for the first select code.
`timescale 1ns/10ps

module atc_timer_tb_top
	import atc_pkg::*;
;
	// ****************************************
	// Signals and design
	// ****************************************
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic [7:0] expect_byte;
	} atc_row_s;

	logic       clk_in;
	logic       nrst_in;
	logic [2:0] addr_in;
	logic [7:0] wdata_in;
	logic       wr_in;
	logic       rd_in;
	logic [7:0] rdata_out;
	logic       crystal_in_pin_in;
	logic       ack_overflow_in;
	logic       ack_compare_in;
	logic       irq_overflow_out;
	logic       irq_compare_out;
	logic       at_bottom_out;
	logic       at_max_out;
	int         failures;
	int         check_count;
	logic [7:0] v;
	atc_row_s   rows [8];

	atc_timer #(.DIV1(1)) uut (
		.clk_in            (clk_in),
		.nrst_in           (nrst_in),
		.addr_in           (addr_in),
		.wdata_in          (wdata_in),
		.wr_in             (wr_in),
		.rd_in             (rd_in),
		.rdata_out         (rdata_out),
		.crystal_in_pin_in (crystal_in_pin_in),
		.ack_overflow_in   (ack_overflow_in),
		.ack_compare_in    (ack_compare_in),
		.irq_overflow_out  (irq_overflow_out),
		.irq_compare_out   (irq_compare_out),
		.at_bottom_out     (at_bottom_out),
		.at_max_out        (at_max_out)
	);

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Caller stands just after a rising edge; one idle edge follows so that
	// a back-to-back call never drives the strobe twice in one time step
	task wr(input logic [2:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask : wr

	// Data stands only in the cycle after the strobe
	task rd(input logic [2:0] a, output logic [7:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		// Sample once the registered data has settled, not at the launching edge
		#1;
		d = rdata_out;
		@(posedge clk_in);
	endtask : rd

	task wait_irq(input bit cmp);
		int n;
		n = 0;
		while (((cmp ? irq_compare_out : irq_overflow_out) !== 1'b1) && n < 600) begin
			@(posedge clk_in);
			n++;
		end
		if (n == 600) begin
			failures++;
			$display("BAD %0t interrupt never came", $time);
			close_out();
		end
	endtask : wait_irq

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		failures = 0;
		check_count = 0;
		nrst_in = 1'b0;
		addr_in = 3'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		crystal_in_pin_in = 1'b0;
		ack_overflow_in = 1'b0;
		ack_compare_in = 1'b0;
		rows = '{'{ATC_ADDR_COUNTER, 8'hA5, 8'hA5}, '{ATC_ADDR_COMPARE, 8'h5A, 8'h5A},
			'{ATC_ADDR_CTRL_A, 8'h0A, 8'h0A}, '{ATC_ADDR_CTRL_A, 8'h00, 8'h00},
			'{ATC_ADDR_MASK, 8'h03, 8'h03}, '{ATC_ADDR_MASK, 8'h00, 8'h00},
			'{ATC_ADDR_ASYNC, 8'h00, 8'h00}, '{3'h7, 8'hFF, 8'h00}};
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk({7'h00, at_bottom_out}, 8'h01);
		chk({7'h00, irq_overflow_out}, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, v);
			chk(v, rows[i].expect_byte);
		end
		$display("register table done");
		// Stopped clock holds the count; max indication follows
		wr(ATC_ADDR_COUNTER, 8'hFF);
		repeat (6) @(posedge clk_in);
		chk({7'h00, at_max_out}, 8'h01);
		rd(ATC_ADDR_COUNTER, v);
		chk(v, 8'hFF);
		$display("stopped hold done");
		// Normal wrap from max raises overflow, masked through
		wr(ATC_ADDR_MASK, 8'h01);
		wr(ATC_ADDR_CTRL_B, 8'h01);
		wait_irq(1'b0);
		wr(ATC_ADDR_CTRL_B, 8'h00);
		rd(ATC_ADDR_FLAGS, v);
		chk(v & 8'h01, 8'h01);
		chk({7'h00, irq_compare_out}, 8'h00);
		wr(ATC_ADDR_FLAGS, 8'h01);
		rd(ATC_ADDR_FLAGS, v);
		chk(v & 8'h01, 8'h00);
		$display("overflow done");
		// Compare match flag, then acknowledge clears it
		wr(ATC_ADDR_COUNTER, 8'h00);
		wr(ATC_ADDR_COMPARE, 8'h05);
		wr(ATC_ADDR_MASK, 8'h02);
		wr(ATC_ADDR_CTRL_B, 8'h01);
		wait_irq(1'b1);
		wr(ATC_ADDR_CTRL_B, 8'h00);
		ack_compare_in <= 1'b1;
		ack_overflow_in <= 1'b1;
		@(posedge clk_in);
		ack_compare_in <= 1'b0;
		ack_overflow_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk({7'h00, irq_compare_out}, 8'h00);
		rd(ATC_ADDR_FLAGS, v);
		chk(v & 8'h02, 8'h00);
		$display("compare done");
		// A counter write equal to compare blocks the next match
		wr(ATC_ADDR_COMPARE, 8'h20);
		wr(ATC_ADDR_COUNTER, 8'h20);
		wr(ATC_ADDR_CTRL_B, 8'h01);
		repeat (20) @(posedge clk_in);
		// The written value wins, then the idle edge of the write counts once more
		wr(ATC_ADDR_COUNTER, 8'h80);
		rd(ATC_ADDR_COUNTER, v);
		chk(v, 8'h81);
		wr(ATC_ADDR_CTRL_B, 8'h00);
		rd(ATC_ADDR_FLAGS, v);
		chk(v & 8'h02, 8'h00);
		$display("write blocking done");
		// Clear on compare keeps the count at or below compare
		wr(ATC_ADDR_CTRL_A, {6'h00, ATC_WGM_CTC});
		wr(ATC_ADDR_COMPARE, 8'h03);
		wr(ATC_ADDR_COUNTER, 8'h00);
		wr(ATC_ADDR_CTRL_B, 8'h01);
		repeat (23) @(posedge clk_in);
		wr(ATC_ADDR_CTRL_B, 8'h00);
		rd(ATC_ADDR_COUNTER, v);
		chk({7'h00, v <= 8'h03}, 8'h01);
		$display("clear on compare done");
		// Crystal source: each pin rising edge is one tick
		wr(ATC_ADDR_CTRL_A, 8'h00);
		wr(ATC_ADDR_ASYNC, 8'h01);
		wr(ATC_ADDR_COUNTER, 8'h00);
		wr(ATC_ADDR_CTRL_B, 8'h01);
		repeat (10) begin
			repeat (5) @(posedge clk_in);
			crystal_in_pin_in <= 1'b1;
			repeat (5) @(posedge clk_in);
			crystal_in_pin_in <= 1'b0;
		end
		repeat (8) @(posedge clk_in);
		wr(ATC_ADDR_CTRL_B, 8'h00);
		rd(ATC_ADDR_COUNTER, v);
		chk(v, 8'h0A);
		$display("crystal source done");
		close_out();
	end

endmodule : atc_timer_tb_top
